// ---- hw/monitor_port.sv ----
// monitor-mode entry, security and serial command interpreter
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "monitor_defs.svh"
module monitor_port
	import monitor_pkg::*;
#(
	parameter logic [7:0] OP_WRITE = 8'h49,
	parameter logic [7:0] OP_INDEXED_WRITE_COMMAND = 8'h19,
	parameter logic [15:0] FLASH_LO = 16'h8000,
	parameter logic [15:0] FLASH_HI = 16'hFFFF
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mode pins
	input wire logic irq_high_test_voltage,
	input wire logic reset_high_test_voltage,
	input wire logic reset_pin_n,
	input wire logic mode_pin_a,
	input wire logic mode_pin_b,
	input wire logic clock_divide_select_pin,
	// serial pin
	input wire logic monitor_serial_pin_in,
	output logic monitor_serial_pin_out,
	output logic monitor_serial_pin_oe,
	// cpu side
	input wire logic swi_exec,
	input wire logic watchdog_disable_bit,
	input wire logic [15:0] stack_pointer,
	output logic run_rti,
	output logic monitor_mode,
	output logic clock_bypass_div2,
	output logic [15:0] reset_vector_addr,
	output logic [15:0] swi_vector_addr,
	output logic watchdog_enable,
	output logic flash_locked,
	// memory port, read data valid the cycle after mem_rd
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata
);
	state_t state_ff, nxt_state, ret_ff, nxt_ret;
	logic [7:0] op_ff, nxt_op;
	logic [23:0] args_ff, nxt_args;
	logic [1:0] argn_ff, nxt_argn;
	logic [1:0] left_ff, nxt_left;
	logic [15:0] ptr_ff, nxt_ptr;
	logic [2:0] seccnt_ff, nxt_seccnt;
	logic secmatch_ff, nxt_secmatch;
	logic sec_ok_ff, nxt_sec_ok;
	logic [7:0] secbyte_ff, nxt_secbyte;
	logic tx_start_ff, nxt_tx_start;
	logic [9:0] tx_frame_ff, nxt_tx_frame;
	logic [3:0] tx_nbits_ff, nxt_tx_nbits;
	logic [15:0] nxt_mem_addr;
	logic nxt_mem_rd, nxt_mem_wr;
	logic [7:0] nxt_mem_wdata;
	logic nxt_run, nxt_monitor, nxt_bypass;
	logic rst_pin_ff;
	logic [15:0] div_ff;
	logic [16:0] tick_cnt_ff;
	logic tick_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic send;
	logic [9:0] send_frame;
	logic [3:0] send_nbits;
	state_t send_ret;
	logic rx_valid, rx_break, tx_busy, tx_done;
	logic [7:0] rx_data;

	// entry decode: test voltage, pin a high, pin b low, serial idle high
	wire logic entry_ok = irq_high_test_voltage & mode_pin_a & ~mode_pin_b
		& monitor_serial_pin_in;
	wire logic reset_rise = reset_pin_n & ~rst_pin_ff;
	wire logic swi_entry = swi_exec & (monitor_mode | entry_ok);
	wire logic cmd_byte = rx_valid & ~rx_break;
	wire logic [7:0] byte_frame_data = mem_rdata;
	wire logic flash_hit = (mem_addr >= FLASH_LO) && (mem_addr <= FLASH_HI);
	// a locked host never sees flash contents
	wire logic [7:0] read_result = (flash_hit & ~sec_ok_ff) ? `UNDEF_DATA
		: byte_frame_data;
	// operand count of the opcode now arriving
	wire logic [1:0] op_args = (rx_data == `OP_READ) ? 2'h2 : (rx_data == OP_WRITE) ? 2'h3
		: (rx_data == OP_INDEXED_WRITE_COMMAND) ? 2'h1 : 2'h0;

	// apb decode
	wire logic apb_setup = psel & ~penable;
	wire logic apb_write = psel & penable & pready_ff & pwrite;
	wire logic hit_div = (paddr == `REG_DIV);
	wire logic hit_status = (paddr == `REG_STATUS);
	wire logic hit_ptr = (paddr == `REG_PTR);
	wire logic apb_hit = hit_div | hit_status | hit_ptr;
	wire logic [31:0] status_word = {28'h000_0000, watchdog_enable, clock_bypass_div2,
		sec_ok_ff, monitor_mode};
	wire logic [31:0] read_word = hit_div ? {16'h0000, div_ff} : hit_status ? status_word
		: hit_ptr ? {16'h0000, ptr_ff} : 32'h0000_0000;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// bit-rate divider: doubled unless the divide-by-two is bypassed
	wire logic [16:0] period = clock_bypass_div2 ? {1'b0, div_ff} : {div_ff, 1'b0};
	wire logic tick_wrap = (tick_cnt_ff >= (period - 17'h0_0001));

	// one tick drives both directions, so rates always match
	monitor_rx u_rx (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick_ff),
		.enable(~tx_busy & ~tx_start_ff),
		.rxd(monitor_serial_pin_in),
		.byte_valid(rx_valid),
		.byte_data(rx_data),
		.byte_break(rx_break)
	);

	monitor_tx u_tx (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick_ff),
		.start(tx_start_ff),
		.frame(tx_frame_ff),
		.nbits(tx_nbits_ff),
		.txd(monitor_serial_pin_out),
		.txoe(monitor_serial_pin_oe),
		.busy(tx_busy),
		.done(tx_done)
	);

	// command interpreter
	always_comb
	begin
		nxt_state = state_ff;
		nxt_ret = ret_ff;
		nxt_op = op_ff;
		nxt_args = args_ff;
		nxt_argn = argn_ff;
		nxt_left = left_ff;
		nxt_ptr = ptr_ff;
		nxt_seccnt = seccnt_ff;
		nxt_secmatch = secmatch_ff;
		nxt_sec_ok = sec_ok_ff;
		nxt_secbyte = secbyte_ff;
		nxt_tx_start = 1'b0;
		nxt_tx_frame = tx_frame_ff;
		nxt_tx_nbits = tx_nbits_ff;
		nxt_mem_addr = mem_addr;
		nxt_mem_rd = 1'b0;
		nxt_mem_wr = 1'b0;
		nxt_mem_wdata = mem_wdata;
		nxt_run = 1'b0;
		nxt_monitor = monitor_mode;
		nxt_bypass = clock_bypass_div2;
		send = 1'b0;
		send_frame = {1'b1, rx_data, 1'b0};
		send_nbits = `FRAME_BITS;
		send_ret = st_cmd;
		case (state_ff)
			st_sec:
				if (rx_valid)
				begin
					nxt_secbyte = rx_data;
					nxt_mem_addr = `SEC_BASE + {13'h0000, seccnt_ff};
					nxt_mem_rd = 1'b1;
					nxt_state = st_secrd;
				end
			st_secrd:
				nxt_state = st_seccmp;
			st_seccmp:
			begin
				nxt_secmatch = secmatch_ff & (mem_rdata == secbyte_ff);
				nxt_seccnt = seccnt_ff + 3'h1;
				nxt_state = st_sec;
				if (seccnt_ff == `SEC_LAST)
				begin
					// a pass sticks until power-on reset
					nxt_sec_ok = sec_ok_ff | nxt_secmatch;
					send = 1'b1;
					send_frame = `BREAK_FRAME;
				end
			end
			st_cmd, st_arg:
				if (rx_valid && rx_break)
				begin
					send = 1'b1;
					send_frame = `HOLD_FRAME;
					send_nbits = `HOLD_BITS;
					send_ret = st_brkecho;
				end
				else if (cmd_byte && state_ff == st_cmd)
				begin
					nxt_op = rx_data;
					nxt_argn = op_args;
					send = 1'b1;
					send_ret = (nxt_argn == 2'h0) ? st_exec : st_arg;
				end
				else if (cmd_byte)
				begin
					// address high byte lands first
					nxt_args = {args_ff[15:0], rx_data};
					nxt_argn = argn_ff - 2'h1;
					send = 1'b1;
					send_ret = (argn_ff == 2'h1) ? st_exec : st_arg;
				end
			st_brkecho:
			begin
				send = 1'b1;
				send_frame = `BREAK_FRAME;
			end
			st_exec:
			begin
				// reached only after the final echo has left
				nxt_state = st_cmd;
				if (op_ff == `OP_READ)
				begin
					nxt_ptr = args_ff[15:0];
					nxt_mem_addr = args_ff[15:0];
					nxt_left = 2'h1;
					nxt_state = st_rdreq;
				end
				else if (op_ff == OP_WRITE || op_ff == OP_INDEXED_WRITE_COMMAND)
				begin
					nxt_ptr = (op_ff == OP_WRITE) ? args_ff[23:8] : ptr_ff + 16'h0001;
					nxt_mem_addr = nxt_ptr;
					nxt_mem_wdata = args_ff[7:0];
					nxt_mem_wr = 1'b1;
				end
				else if (op_ff == `OP_INDEXED_READ_COMMAND)
				begin
					nxt_ptr = ptr_ff + 16'h0001; // wraps over 64K
					nxt_mem_addr = nxt_ptr;
					nxt_left = 2'h2;
					nxt_state = st_rdreq;
				end
				else if (op_ff == `OP_READ_STACK_POINTER_COMMAND)
				begin
					nxt_args = {8'h00, stack_pointer};
					send = 1'b1;
					send_frame = {1'b1, stack_pointer[15:8], 1'b0};
					send_ret = st_splo;
				end
				else if (op_ff == `OP_RUN)
				begin
					// host code written to RAM runs from here
					nxt_run = 1'b1;
					nxt_state = st_run;
				end
			end
			st_splo:
			begin
				send = 1'b1;
				send_frame = {1'b1, args_ff[7:0], 1'b0};
			end
			st_rdreq:
			begin
				nxt_mem_rd = 1'b1;
				nxt_state = st_rdwait;
			end
			st_rdwait:
				nxt_state = st_rdget;
			st_rdget:
			begin
				nxt_left = left_ff - 2'h1;
				send = 1'b1;
				send_frame = {1'b1, read_result, 1'b0};
				send_ret = (left_ff == 2'h1) ? st_cmd : st_rdnext;
			end
			st_rdnext:
			begin
				nxt_ptr = ptr_ff + 16'h0001;
				nxt_mem_addr = nxt_ptr;
				nxt_state = st_rdreq;
			end
			st_txw:
				if (tx_done)
					nxt_state = ret_ff;
			st_user, st_run:
				nxt_state = state_ff;
			default:
				nxt_state = st_user;
		endcase
		if (send)
		begin
			nxt_tx_start = 1'b1;
			nxt_tx_frame = send_frame;
			nxt_tx_nbits = send_nbits;
			nxt_ret = send_ret;
			nxt_state = st_txw;
		end
		// software interrupt re-enters monitor and signals ready
		if (swi_entry && !reset_rise)
		begin
			nxt_monitor = 1'b1;
			nxt_tx_start = 1'b1;
			nxt_tx_frame = `BREAK_FRAME;
			nxt_tx_nbits = `FRAME_BITS;
			nxt_ret = st_cmd;
			nxt_state = st_txw;
		end
		// reset pin released: mode decided, security wait restarts
		if (reset_rise)
		begin
			nxt_monitor = entry_ok;
			nxt_bypass = entry_ok & ~clock_divide_select_pin;
			nxt_seccnt = 3'h0;
			nxt_secmatch = 1'b1;
			nxt_tx_start = 1'b0;
			nxt_mem_rd = 1'b0;
			nxt_mem_wr = 1'b0;
			nxt_state = entry_ok ? st_sec : st_user;
		end
	end

	// interpreter registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= st_user;
			ret_ff <= st_cmd;
			op_ff <= 8'h00;
			args_ff <= 24'h00_0000;
			argn_ff <= 2'h0;
			left_ff <= 2'h0;
			ptr_ff <= 16'h0000;
			seccnt_ff <= 3'h0;
			secmatch_ff <= 1'b1;
			sec_ok_ff <= 1'b0;
			secbyte_ff <= 8'h00;
			tx_start_ff <= 1'b0;
			tx_frame_ff <= `HOLD_FRAME;
			tx_nbits_ff <= `FRAME_BITS;
			mem_addr <= 16'h0000;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			run_rti <= 1'b0;
			monitor_mode <= 1'b0;
			clock_bypass_div2 <= 1'b0;
			rst_pin_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			ret_ff <= nxt_ret;
			op_ff <= nxt_op;
			args_ff <= nxt_args;
			argn_ff <= nxt_argn;
			left_ff <= nxt_left;
			ptr_ff <= nxt_ptr;
			seccnt_ff <= nxt_seccnt;
			secmatch_ff <= nxt_secmatch;
			sec_ok_ff <= nxt_sec_ok;
			secbyte_ff <= nxt_secbyte;
			tx_start_ff <= nxt_tx_start;
			tx_frame_ff <= nxt_tx_frame;
			tx_nbits_ff <= nxt_tx_nbits;
			mem_addr <= nxt_mem_addr;
			mem_rd <= nxt_mem_rd;
			mem_wr <= nxt_mem_wr;
			mem_wdata <= nxt_mem_wdata;
			run_rti <= nxt_run;
			monitor_mode <= nxt_monitor;
			clock_bypass_div2 <= nxt_bypass;
			rst_pin_ff <= reset_pin_n;
		end
	end

	// vectors, watchdog gate and flash lock, all registered
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reset_vector_addr <= `VEC_RST_USER;
			swi_vector_addr <= `VEC_SWI_USER;
			watchdog_enable <= 1'b0;
			flash_locked <= 1'b1;
		end
		else
		begin
			reset_vector_addr <= monitor_mode ? `VEC_RST_MON : `VEC_RST_USER;
			swi_vector_addr <= monitor_mode ? `VEC_SWI_MON : `VEC_SWI_USER;
			watchdog_enable <= ~watchdog_disable_bit & ~(monitor_mode
				& (irq_high_test_voltage | reset_high_test_voltage));
			flash_locked <= monitor_mode & ~sec_ok_ff;
		end
	end

	// divider and apb slave; zero divisor writes are dropped to keep ticks alive
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_ff <= `TICK_DIV_RST;
			tick_cnt_ff <= 17'h0_0000;
			tick_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= tick_wrap;
			tick_cnt_ff <= tick_wrap ? 17'h0_0000 : tick_cnt_ff + 17'h0_0001;
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & ~apb_hit;
			if (apb_setup)
				prdata_ff <= read_word;
			if (apb_write && hit_div && pwdata[15:0] != 16'h0000)
				div_ff <= pwdata[15:0];
		end
	end

	property p_silent_sec;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_sec) |-> !tx_start_ff;
	endproperty
	a_silent_sec: assert property (p_silent_sec) else $error("sent during security wait");

	property p_ready_break;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_seccmp && seccnt_ff == `SEC_LAST && !reset_rise && !swi_entry)
		|=> tx_start_ff && tx_frame_ff == `BREAK_FRAME && tx_nbits_ff == `FRAME_BITS;
	endproperty
	a_ready_break: assert property (p_ready_break) else $error("no break after security");

	property p_echo;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_cmd && cmd_byte && !reset_rise && !swi_entry)
		|=> tx_start_ff && tx_frame_ff[8:1] == $past(rx_data);
	endproperty
	a_echo: assert property (p_echo) else $error("byte not echoed");

	property p_break_hold;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_cmd && rx_valid && rx_break && !reset_rise && !swi_entry)
		|=> tx_frame_ff == `HOLD_FRAME && tx_nbits_ff == `HOLD_BITS ##1 state_ff == st_txw;
	endproperty
	a_break_hold: assert property (p_break_hold) else $error("break not answered high");

	property p_vectors;
		@(posedge clock) disable iff (!rst_n)
		1'b1 |=> reset_vector_addr == ($past(monitor_mode) ? `VEC_RST_MON : `VEC_RST_USER);
	endproperty
	a_vectors: assert property (p_vectors) else $error("wrong reset vector");

	property p_watchdog_off;
		@(posedge clock) disable iff (!rst_n)
		(monitor_mode && irq_high_test_voltage) |=> !watchdog_enable;
	endproperty
	a_watchdog_off: assert property (p_watchdog_off) else $error("watchdog on under test voltage");

	property p_locked_read;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_rdget && flash_hit && !sec_ok_ff && !reset_rise && !swi_entry)
		|=> tx_frame_ff[8:1] == `UNDEF_DATA;
	endproperty
	a_locked_read: assert property (p_locked_read) else $error("flash leaked while locked");

	property p_indexed_read_command_step;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_exec && op_ff == `OP_INDEXED_READ_COMMAND && !reset_rise && !swi_entry)
		|=> ptr_ff == $past(ptr_ff) + 16'h0001 && left_ff == 2'h2;
	endproperty
	a_indexed_read_command_step: assert property (p_indexed_read_command_step) else $error("indexed read pointer wrong");

	property p_run;
		@(posedge clock) disable iff (!rst_n)
		(state_ff == st_exec && op_ff == `OP_RUN && !reset_rise && !swi_entry)
		|=> run_rti && state_ff == st_run ##1 !run_rti;
	endproperty
	a_run: assert property (p_run) else $error("run did not return");
endmodule

// ---- hw/monitor_defs.svh ----
// constants for the monitor-mode command port
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH
// register byte offsets
`define REG_DIV 8'h00
`define REG_STATUS 8'h04
`define REG_PTR 8'h08
// command opcodes
`define OP_READ 8'h4A
`define OP_INDEXED_READ_COMMAND 8'h1A
`define OP_READ_STACK_POINTER_COMMAND 8'h0C
`define OP_RUN 8'h28
// vector addresses
`define VEC_RST_MON 16'hFEFE
`define VEC_RST_USER 16'hFFFE
`define VEC_SWI_MON 16'hFEFC
`define VEC_SWI_USER 16'hFFFC
// security
`define SEC_BASE 16'hFFF6
`define SEC_LAST 3'h7
`define UNDEF_DATA 8'h00
// serial timing: generator cycles per bit and oversampling
`define BIT_DIV 16'h0228
`define OVERSAMPLE 16'h0008
`define TICK_DIV_RST (`BIT_DIV / `OVERSAMPLE)
`define PHASE_LAST 3'h7
`define SAMPLE_PHASE 3'h3
`define FRAME_BITS 4'hA
`define HOLD_BITS 4'h2
`define BREAK_FRAME 10'h000
`define HOLD_FRAME 10'h3FF
`endif

// ---- hw/monitor_pkg.sv ----
// types shared by the monitor-mode command port
package monitor_pkg;
	typedef enum logic [14:0] {
		st_user = 15'h0001,
		st_sec = 15'h0002,
		st_secrd = 15'h0004,
		st_seccmp = 15'h0008,
		st_cmd = 15'h0010,
		st_arg = 15'h0020,
		st_exec = 15'h0040,
		st_rdreq = 15'h0080,
		st_rdwait = 15'h0100,
		st_rdget = 15'h0200,
		st_rdnext = 15'h0400,
		st_splo = 15'h0800,
		st_brkecho = 15'h1000,
		st_txw = 15'h2000,
		st_run = 15'h4000
	} state_t;
endpackage

// ---- hw/monitor_rx.sv ----
// serial receiver with break detection
`timescale 1ns/100ps
`include "monitor_defs.svh"
module monitor_rx
	import monitor_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// oversample tick and line
	input wire logic tick,
	input wire logic enable,
	input wire logic rxd,
	// received character
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic byte_break
);
	logic busy_ff;
	logic line_ff;
	logic valid_ff;
	logic [2:0] phase_ff;
	logic [3:0] bit_ff;
	logic [8:0] shift_ff;
	// start needs a high-to-low edge so a long break is not seen twice
	wire logic start_edge = enable & tick & line_ff & ~rxd;
	wire logic sample = tick & (phase_ff == `SAMPLE_PHASE);
	wire logic last_bit = (bit_ff == (`FRAME_BITS - 4'h1));
	assign byte_valid = valid_ff;
	assign byte_data = shift_ff[7:0];
	assign byte_break = ~|shift_ff;
	// frame sampler, mid-bit at oversample phase three
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_ff <= 1'b0;
			line_ff <= 1'b1;
			valid_ff <= 1'b0;
			phase_ff <= 3'h0;
			bit_ff <= 4'h0;
			shift_ff <= 9'h1FF;
		end
		else
		begin
			valid_ff <= 1'b0;
			if (tick)
				line_ff <= rxd;
			if (!busy_ff)
			begin
				phase_ff <= 3'h0;
				bit_ff <= 4'h0;
				busy_ff <= start_edge;
			end
			else if (tick)
			begin
				phase_ff <= phase_ff + 3'h1;
				if (sample)
				begin
					bit_ff <= bit_ff + 4'h1;
					shift_ff <= {rxd, shift_ff[8:1]}; // lsb first
					if (bit_ff == 4'h0 && rxd)
						busy_ff <= 1'b0; // false start, a glitch
					else if (last_bit)
					begin
						busy_ff <= 1'b0;
						valid_ff <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// ---- hw/monitor_tx.sv ----
// serial transmitter for bytes, breaks and idle-high holds
`timescale 1ns/100ps
`include "monitor_defs.svh"
module monitor_tx
	import monitor_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// oversample tick
	input wire logic tick,
	// request
	input wire logic start,
	input wire logic [9:0] frame,
	input wire logic [3:0] nbits,
	// line and status
	output logic txd,
	output logic txoe,
	output logic busy,
	output logic done
);
	logic [9:0] shift_ff;
	logic [3:0] left_ff;
	logic [2:0] phase_ff;
	wire logic bit_end = tick & (phase_ff == `PHASE_LAST);
	// shift out lsb first; pin driven both ways only while sending
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_ff <= 10'h3FF;
			left_ff <= 4'h0;
			phase_ff <= 3'h0;
			txd <= 1'b1;
			txoe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				shift_ff <= frame;
				left_ff <= nbits;
				phase_ff <= 3'h0;
				txd <= frame[0];
				txoe <= 1'b1;
				busy <= 1'b1;
			end
			else if (busy && tick)
			begin
				phase_ff <= phase_ff + 3'h1;
				if (bit_end && left_ff == 4'h1)
				begin
					txd <= 1'b1;
					txoe <= 1'b0;
					busy <= 1'b0;
					done <= 1'b1;
				end
				else if (bit_end)
				begin
					shift_ff <= {1'b1, shift_ff[9:1]};
					txd <= shift_ff[1];
					left_ff <= left_ff - 4'h1;
				end
			end
		end
	end
endmodule

// ---- bench/host_model.sv ----
// host computer behind the single-wire monitor line
`timescale 1ns/100ps
module host_model #(parameter int BIT = 16)
(
	// clock and line
	input wire logic clock,
	input wire logic dev_low,
	output logic line
);
	logic host_low = 1'b0;
	// pull-up makes the line a wired-or of both pull-downs
	assign line = ~(dev_low | host_low);
	// one frame, or ten low bits for a break; stop cut short so an echo is not missed
	task automatic send(input logic [7:0] b, input logic brk);
		logic [9:0] f;
		f = brk ? 10'h000 : {1'b1, b, 1'b0};
		repeat (BIT) @(posedge clock);
		for (int i = 0; i < 10; i++)
		begin
			host_low <= ~f[i];
			repeat (i == 9 && !brk ? BIT / 2 : BIT) @(posedge clock);
		end
		host_low <= 1'b0;
	endtask
	// wait for a start bit, then sample mid-bit, lsb first
	task automatic recv(output logic [7:0] b);
		int n;
		n = 0;
		while (line !== 1'b0 && n < 4000)
		begin
			@(posedge clock);
			n++;
		end
		repeat (BIT + BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = line;
			repeat (BIT) @(posedge clock);
		end
		if (n == 4000)
			b = 8'hxx;
	endtask
endmodule

// ---- bench/monitor_mode_command_port_bench.sv ----
// self-checking bench for the monitor-mode command port
`timescale 1ns/100ps
module monitor_mode_command_port_bench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, r;
	logic [31:0] prdata;
	logic pready, pslverr, run_rti, mode, bypass, wd_en, locked, mem_rd, mem_wr;
	logic tx_out, tx_oe, line, e;
	logic irq_hv = 1'b0, pin_n = 1'b0, mpa = 1'b0, software_interrupt_instruction = 1'b0, quiet = 1'b0;
	logic cds = 1'b0, wdd = 1'b0;
	logic [15:0] rvec, svec, mem_addr;
	logic [7:0] mem_wdata, b;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] mem [0:65535];
	int fail_count = 0, n_compared = 0, runs = 0, noisy = 0;
	// opcode or operand, result count, result bytes high first
	logic [27:0] rows [22] = '{28'h4A0_0000, 28'h800_0000, 28'h101_4A00, 28'h1A2_4B48,
		28'h0C2_A5C3, 28'h490_0000, 28'h120_0000, 28'h340_0000, 28'h770_0000,
		28'h4A0_0000, 28'h120_0000, 28'h341_7700, 28'h190_0000, 28'h660_0000,
		28'h4A0_0000, 28'h120_0000, 28'h351_6600, 28'h4A0_0000, 28'hFF0_0000,
		28'hFF1_A500, 28'h1A2_5A5B, 28'h280_0000};

	always #2 clock = ~clock;

	monitor_port u_monitor_port (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_high_test_voltage(irq_hv), .reset_high_test_voltage(1'b0),
		.reset_pin_n(pin_n), .mode_pin_a(mpa), .mode_pin_b(1'b0),
		.clock_divide_select_pin(cds), .monitor_serial_pin_in(line),
		.monitor_serial_pin_out(tx_out), .monitor_serial_pin_oe(tx_oe),
		.swi_exec(software_interrupt_instruction), .watchdog_disable_bit(wdd), .stack_pointer(16'hA5C3),
		.run_rti(run_rti), .monitor_mode(mode), .clock_bypass_div2(bypass),
		.reset_vector_addr(rvec), .swi_vector_addr(svec), .watchdog_enable(wd_en),
		.flash_locked(locked), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	host_model #(.BIT(16)) u_host_model (.clock(clock), .dev_low(tx_oe & ~tx_out),
		.line(line));

	// one-cycle memory, counters of run pulses and of driving while silent
	always @(posedge clock)
	begin
		if (mem_rd)
			mem_rdata <= mem[mem_addr];
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
		if (run_rti === 1'b1)
			runs++;
		if (quiet && tx_oe !== 1'b0)
			noisy++;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// setup, then access held until pready; an edge first so two calls never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one row: send a byte, check its echo, then any result bytes
	task automatic xfer(input logic [27:0] row);
		u_host_model.send(row[27:20], 1'b0);
		u_host_model.recv(b);
		chk(b, row[27:20]);
		for (int k = 0; k < row[17:16]; k++)
		begin
			u_host_model.recv(b);
			chk(b, k ? row[7:0] : row[15:8]);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#200000;
		fail_count++;
		complete_run();
	end

	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ 8'h5A;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		chk({mode, rvec, svec}, {1'b0, 16'hFFFE, 16'hFFFC});
		apb(1'b1, 8'h00, 32'h0000_0002);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk({e, r}, 33'h0_0000_0002);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk({e, r}, 33'h1_0000_0000);
		// entry pins then the reset pin rises; silence until eight bytes
		irq_hv <= 1'b1;
		mpa <= 1'b1;
		quiet <= 1'b1;
		@(posedge clock);
		pin_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk(mode, 1'b1);
		chk(bypass, 1'b1);
		chk({rvec, svec}, {16'hFEFE, 16'hFEFC});
		chk(wd_en, 1'b0);
		for (int i = 0; i < 8; i++)
			u_host_model.send((8'hF6 + i[7:0]) ^ 8'h5A, 1'b0);
		quiet <= 1'b0;
		u_host_model.recv(b);
		chk(noisy, 0);
		chk(b, 8'h00);
		chk(locked, 1'b0);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(r[1:0], 2'b11);
		foreach (rows[i])
			xfer(rows[i]);
		// the run pulse only follows the end of the last echo
		repeat (32) @(posedge clock);
		chk(runs, 1);
		// software interrupt re-entry, then a host break
		software_interrupt_instruction <= 1'b1;
		@(posedge clock);
		software_interrupt_instruction <= 1'b0;
		u_host_model.recv(b);
		chk(b, 8'h00);
		u_host_model.send(8'h00, 1'b1);
		repeat (16) @(posedge clock);
		chk({tx_oe, line}, 2'b11);
		u_host_model.recv(b);
		chk(b, 8'h00);
		irq_hv <= 1'b0;
		repeat (3) @(posedge clock);
		chk(wd_en, 1'b1);
		wdd <= 1'b1;
		repeat (3) @(posedge clock);
		chk(wd_en, 1'b0);
		// reset pin pulse: security wait again, but the pass is kept
		irq_hv <= 1'b1;
		pin_n <= 1'b0;
		repeat (2) @(posedge clock);
		pin_n <= 1'b1;
		repeat (3) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(r[3:0], 4'h7);
		// power-on reset, divide-by-two kept, then wrong security bytes
		rst_n <= 1'b0;
		pin_n <= 1'b0;
		cds <= 1'b1;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		chk({mode, locked, rvec}, {2'b00, 16'hFFFE});
		apb(1'b1, 8'h00, 32'h0000_0001);
		pin_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk({mode, bypass}, 2'b10);
		for (int i = 0; i < 8; i++)
			u_host_model.send(8'h11, 1'b0);
		u_host_model.recv(b);
		chk(b, 8'h00);
		chk(locked, 1'b1);
		// a locked host reads flash as zero
		xfer(28'h4A0_0000);
		xfer(28'h800_0000);
		xfer(28'h101_0000);
		complete_run();
	end
endmodule
